// ==== design/crs_serializer.v ====
// configuration loader and serial readback engine with apb registers
`timescale 1ns/100ps
`include "crs_regs.vh"
module crs_serializer (
  input wire CLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire CFG_CLK,
  input wire CFG_DIN,
  output reg INIT_N,
  input wire READBACK_USER_CLK,
  input wire READBACK_TRIGGER,
  output reg READBACK_DATA,
  output reg READBACK_IN_PROGRESS,
  input wire [7:0] USER_NODES,
  input wire RAM_WE,
  input wire [2:0] RAM_FRAME,
  input wire [15:0] RAM_DATA
);
  // ************************************************************
  // state codes
  // ************************************************************
  localparam R_IDLE = 6'h01;
  localparam R_ARM = 6'h02;
  localparam R_DUMMY = 6'h04;
  localparam R_FRAME = 6'h08;
  localparam R_SIG = 6'h10;
  localparam R_DRAIN = 6'h20;
  localparam L_HDR = 6'h01;
  localparam L_LEN = 6'h02;
  localparam L_DUM = 6'h04;
  localparam L_FRM = 6'h08;
  localparam L_POST = 6'h10;
  localparam L_WAIT = 6'h20;

  // serial crc-16 ccitt step
  function [15:0] crc_step;
    input [15:0] c;
    input b;
    begin
      crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CRS_CRC_POLY : 16'h0000);
    end
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  reg [11:0] sy1_r;
  reg [11:0] sy2_r;
  wire cclk_s = sy2_r[0];
  wire cdin_s = sy2_r[1];
  wire uclk_s = sy2_r[2];
  wire trig_s = sy2_r[3];
  wire [7:0] nodes_s = sy2_r[11:4];

  // two stages for the config pins, user clock, trigger and node inputs (ram and apb inputs unsynchronised), logic reads only stage two
  always @(posedge CLK) begin
    if (RST) begin
      sy1_r <= 12'h000;
      sy2_r <= 12'h000;
    end else begin
      sy1_r <= {USER_NODES, READBACK_TRIGGER, READBACK_USER_CLK,
                CFG_DIN, CFG_CLK};
      sy2_r <= sy1_r;
    end
  end

  // ************************************************************
  // control register and clock edges
  // ************************************************************
  reg [4:0] ctrl_r;
  reg rclk_d_r;
  reg cclk_d_r;
  wire cap_on = ctrl_r[`CRS_CTRL_CAPTURE];
  wire abort_on = ctrl_r[`CRS_CTRL_ABORT];
  wire check_on = ctrl_r[`CRS_CTRL_CHECK];
  // glitch hazard if the source is changed mid readback
  wire rclk_sel = ctrl_r[`CRS_CTRL_CLKSRC] ? uclk_s : cclk_s;
  wire rck = rclk_sel & ~rclk_d_r;
  wire cck = cclk_s & ~cclk_d_r;

  // edge finders run on the system clock
  always @(posedge CLK) begin
    if (RST) begin
      rclk_d_r <= 1'b0;
      cclk_d_r <= 1'b0;
    end else begin
      rclk_d_r <= rclk_sel;
      cclk_d_r <= cclk_s;
    end
  end

  // ************************************************************
  // frame store
  // ************************************************************
  reg l_we_r;
  reg [2:0] l_frm_r;
  reg [15:0] l_sh_r;
  reg [2:0] frm_r;
  wire [15:0] mem_q;
  wire mem_we = l_we_r | RAM_WE;
  // loader wins; logic cell ram writes land in config data
  wire [2:0] mem_wa = l_we_r ? l_frm_r : RAM_FRAME;
  wire [15:0] mem_wd = l_we_r ? l_sh_r : RAM_DATA;

  crs_frame_mem u_mem (
    .clk(CLK),
    .we(mem_we),
    .waddr(mem_wa),
    .wdata(mem_wd),
    .raddr(frm_r),
    .rdata(mem_q)
  );

  // ************************************************************
  // configuration loader
  // ************************************************************
  reg [5:0] lst_r;
  reg [4:0] lcnt_r;
  reg [3:0] pre_r;
  reg [23:0] len_r;
  reg [23:0] tot_r;
  reg [15:0] lcrc_r;
  reg [2:0] chk_r;
  reg done_r;
  wire [23:0] tot_nxt = tot_r + 24'h000001;
  wire [3:0] chk_nxt = {chk_r, cdin_s};
  wire len_known = (lst_r != L_HDR) && (lst_r != L_LEN);

  // one bit per config clock rise, total bounded by length count
  always @(posedge CLK) begin
    if (RST) begin
      lst_r <= L_HDR;
      lcnt_r <= 5'h00;
      pre_r <= 4'hF;
      len_r <= 24'h000000;
      tot_r <= 24'h000000;
      lcrc_r <= 16'h0000;
      chk_r <= 3'h0;
      l_sh_r <= 16'h0000;
      l_frm_r <= 3'h0;
      l_we_r <= 1'b0;
      done_r <= 1'b0;
      INIT_N <= 1'b1;
    end else begin
      l_we_r <= 1'b0;
      if (cck && !done_r && lst_r != L_WAIT) begin
        tot_r <= tot_nxt; // leading extra ones are counted
        if (len_known && tot_nxt == len_r) begin
          done_r <= 1'b1;
        end
        case (lst_r)
          L_HDR: begin
            pre_r <= {pre_r[2:0], cdin_s};
            if ({pre_r[2:0], cdin_s} == `CRS_PREAMBLE) begin
              lst_r <= L_LEN;
              lcnt_r <= 5'h00;
            end
          end
          L_LEN: begin
            len_r <= {len_r[22:0], cdin_s};
            lcnt_r <= lcnt_r + 5'h01;
            if (lcnt_r == `CRS_LEN_LAST) begin
              lst_r <= L_DUM;
              lcnt_r <= 5'h00;
            end
          end
          L_DUM: begin
            lcnt_r <= lcnt_r + 5'h01;
            if (lcnt_r == `CRS_HDR_DUMMY_LAST) begin
              lst_r <= L_FRM;
              lcnt_r <= 5'h00;
            end
          end
          L_FRM: begin
            if (lcnt_r == 5'h00) begin
              lcrc_r <= 16'h0000;
              if (!cdin_s) begin
                lcnt_r <= 5'h01; // start bit
              end else if (check_on) begin
                lst_r <= L_WAIT;
                INIT_N <= 1'b0;
              end
            end else if (lcnt_r <= `CRS_DW) begin
              l_sh_r <= {l_sh_r[14:0], cdin_s};
              lcrc_r <= crc_step(lcrc_r, cdin_s);
              lcnt_r <= lcnt_r + 5'h01;
            end else if (lcnt_r != `CRS_FRM_LEN_LAST) begin
              chk_r <= chk_nxt[2:0];
              lcnt_r <= lcnt_r + 5'h01;
            end else if (check_on && chk_nxt != lcrc_r[3:0]) begin
              lst_r <= L_WAIT; // abort and hold init low
              INIT_N <= 1'b0;
            end else begin
              l_we_r <= 1'b1; // four check bits done
              lcnt_r <= 5'h00;
              l_frm_r <= l_frm_r + 3'h1;
              if (l_frm_r == `CRS_FRM_LAST) begin
                lst_r <= L_POST;
              end
            end
          end
          L_POST: begin
            lcnt_r <= 5'h00; // postamble bits only counted
          end
          default: begin
            lst_r <= L_WAIT;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // readback frame bit selection
  // ************************************************************
  reg [5:0] rst_r;
  reg [4:0] bcnt_r;
  reg [3:0] cnt_r;
  reg [7:0] cap_r;
  reg [15:0] crc_r;
  reg [10:0] sig_r;
  reg trig_q_r;
  reg fbit;
  wire [4:0] did = bcnt_r - 5'h01;
  wire [3:0] didx = `CRS_DW_LAST - did[3:0];

  // start, msb-first data with overrides, then stop ones
  always @* begin
    fbit = 1'b1; // stop bits
    if (bcnt_r == 5'h00) begin
      fbit = 1'b0;
    end else if (bcnt_r <= `CRS_DW) begin
      fbit = mem_q[didx]; // uninverted
      if (frm_r == 3'h0 && did < 5'h02) begin
        fbit = (did == 5'h00) ? ctrl_r[`CRS_CTRL_SPEED] :
               ctrl_r[`CRS_CTRL_CHECK];
      end else if (frm_r == `CRS_FRM_LAST &&
                   did >= `CRS_LAST_ONES_FROM) begin
        fbit = 1'b1;
      end else if (did == `CRS_USER_POS) begin
        fbit = cap_on ? ~cap_r[frm_r] : 1'b1;
      end
    end
  end

  // ************************************************************
  // readback sequencer
  // ************************************************************
  wire [15:0] crc_nxt = crc_step(crc_r, fbit);
  wire trig_rise = trig_s & ~trig_q_r;
  wire trig_fall = ~trig_s & trig_q_r;
  wire busy = (rst_r != R_IDLE) && (rst_r != R_DRAIN);

  // advances only on readback clock rises
  always @(posedge CLK) begin
    if (RST) begin
      rst_r <= R_IDLE;
      bcnt_r <= 5'h00;
      cnt_r <= 4'h0;
      frm_r <= 3'h0;
      cap_r <= 8'h00;
      crc_r <= 16'h0000;
      sig_r <= 11'h000;
      trig_q_r <= 1'b0;
      READBACK_DATA <= 1'b1;
      READBACK_IN_PROGRESS <= 1'b0;
    end else if (rck) begin
      trig_q_r <= trig_s;
      if (busy && abort_on && trig_fall) begin
        rst_r <= R_DRAIN;
        READBACK_DATA <= 1'b1;
        cnt_r <= 4'h0;
      end else begin
        case (rst_r)
          R_IDLE: begin
            if (trig_rise) begin
              rst_r <= R_ARM;
              cap_r <= nodes_s;
              crc_r <= 16'h0000;
              frm_r <= 3'h0;
              bcnt_r <= 5'h00;
            end
          end
          R_ARM: begin
            READBACK_IN_PROGRESS <= 1'b1;
            READBACK_DATA <= 1'b1;
            cnt_r <= 4'h1;
            rst_r <= R_DUMMY;
          end
          R_DUMMY: begin
            READBACK_DATA <= 1'b1;
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r[2:0] == `CRS_RB_DUMMY_LAST) begin
              rst_r <= R_FRAME;
            end
          end
          R_FRAME: begin
            READBACK_DATA <= fbit;
            crc_r <= crc_nxt;
            bcnt_r <= bcnt_r + 5'h01;
            if (bcnt_r == `CRS_FRM_LEN_LAST) begin
              bcnt_r <= 5'h00;
              frm_r <= frm_r + 3'h1;
              if (frm_r == `CRS_FRM_LAST) begin
                rst_r <= R_SIG;
                sig_r <= crc_nxt[15:5];
                cnt_r <= 4'h0;
              end
            end
          end
          R_SIG: begin
            READBACK_DATA <= crc_r[15]; // msb first
            crc_r <= {crc_r[14:0], 1'b0};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == `CRS_SIG_LAST) begin
              rst_r <= R_IDLE;
              READBACK_IN_PROGRESS <= 1'b0;
            end
          end
          R_DRAIN: begin
            READBACK_DATA <= 1'b1;
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == `CRS_DRAIN_LAST) begin
              rst_r <= R_IDLE;
              READBACK_IN_PROGRESS <= 1'b0;
            end
          end
          default: begin
            rst_r <= R_IDLE;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // apb slave
  // ************************************************************
  wire apb_go = PSEL & PENABLE & ~PREADY;
  wire [31:0] status = {27'h0000000, rst_r == R_DRAIN, done_r,
                        lst_r == L_WAIT, INIT_N, READBACK_IN_PROGRESS};

  // answers in the second access cycle; unmapped gives slverr
  always @(posedge CLK) begin
    if (RST) begin
      ctrl_r <= `CRS_CTRL_RESET;
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= apb_go;
      PSLVERR <= 1'b0;
      if (apb_go) begin
        PRDATA <= 32'h00000000;
        case (PADDR)
          `CRS_OFF_CTRL: begin
            PRDATA <= {27'h0000000, ctrl_r};
            if (PWRITE) begin
              ctrl_r <= PWDATA[4:0];
            end
          end
          `CRS_OFF_STATUS: begin
            PRDATA <= status;
          end
          `CRS_OFF_LENGTH: begin
            PRDATA <= {8'h00, len_r};
          end
          `CRS_OFF_SIG: begin
            PRDATA <= {21'h000000, sig_r};
          end
          default: begin
            PSLVERR <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule // crs_serializer

// ==== design/crs_regs.vh ====
// constants for the configuration readback serializer
// Operation
// - config frames are start bit 0, data field, four check bits.
// - loader accepts as many bits as the 24-bit length count says.
// - frame check failure aborts load, drives init low, waits.
// - readback output starts with five dummy bits.
// - readback frame is start bit 0, data field, stop bits 1111.
// - readback ends with 11 signature bits after last frame.
// - configuration bits read back with their loaded polarity.
// - captured user node values are sent inverted.
// - first two bits of first frame show speed and check mode.
// - last seven bits of last frame are always ones.
// - capture option off (default): user bit positions send one.
// - logic cell memory contents appear in configuration data portion.
// - abort option on (default off): trigger fall stops readback.
// - serial output held high while draining after abort.
// - in-progress output shows completion, also of aborted sequence.
// - readback clock from config clock pin (default) or user net.
// - signature is top 11 bits of CRC-16 CCITT over stream.
// - each readback clock rise moves one bit onto serial output.
// - trigger rise held one readback clock starts readback, latches nodes.
// - in-progress rises one clock after trigger, falls with last bit.
`ifndef CRS_REGS_VH
`define CRS_REGS_VH
// ************************************************************
// stream format
// ************************************************************
`define CRS_DW 5'h10
`define CRS_DW_LAST 4'hF
`define CRS_FRM_LEN_LAST 5'h14
`define CRS_NFRAMES 8
`define CRS_FRM_LAST 3'h7
`define CRS_USER_POS 5'h04
`define CRS_RB_DUMMY_LAST 3'h4
`define CRS_LAST_ONES_FROM 5'h09
`define CRS_SIG_LAST 4'hA
`define CRS_DRAIN_LAST 4'hA
`define CRS_CRC_POLY 16'h1021
`define CRS_PREAMBLE 4'h2
`define CRS_LEN_LAST 5'h17
`define CRS_HDR_DUMMY_LAST 5'h03
// ************************************************************
// register map
// ************************************************************
`define CRS_OFF_CTRL 12'h000
`define CRS_OFF_STATUS 12'h004
`define CRS_OFF_LENGTH 12'h008
`define CRS_OFF_SIG 12'h00C
`define CRS_CTRL_CAPTURE 0
`define CRS_CTRL_ABORT 1
`define CRS_CTRL_CLKSRC 2
`define CRS_CTRL_SPEED 3
`define CRS_CTRL_CHECK 4
`define CRS_CTRL_RESET 5'h00
`endif

// ==== design/crs_frame_mem.v ====
// frame store holding configuration memory, one frame per word
`timescale 1ns/100ps
module crs_frame_mem (
  input wire clk,
  input wire we,
  input wire [2:0] waddr,
  input wire [15:0] wdata,
  input wire [2:0] raddr,
  output reg [15:0] rdata
);
  reg [15:0] mem [0:7];

  // one write port, registered read port
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // crs_frame_mem

// ==== tb/crs_serializer_checker.sv ====
// port-level assertions for the readback serializer
`timescale 1ns/100ps
module crs_serializer_checker (
  input wire CLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire [11:0] PADDR,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire CFG_CLK,
  input wire READBACK_USER_CLK,
  input wire READBACK_TRIGGER,
  input wire INIT_N,
  input wire READBACK_DATA,
  input wire READBACK_IN_PROGRESS
);
  logic pin_d_r;
  logic [3:0] since_r;
  // cycles since a clock pin rose; the synchroniser delays every move
  always @(posedge CLK) begin
    if (RST) begin
      pin_d_r <= 1'b0;
      since_r <= 4'hF;
    end else begin
      pin_d_r <= CFG_CLK | READBACK_USER_CLK;
      if ((CFG_CLK | READBACK_USER_CLK) && !pin_d_r)
        since_r <= 4'h0;
      else if (since_r != 4'hF)
        since_r <= since_r + 4'h1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_rb_start;
    $rose(READBACK_IN_PROGRESS);
  endsequence
  sequence s_dummies;
    READBACK_DATA [*8];
  endsequence
  AST_INIT_STAYS_LOW: assert property (!INIT_N |=> !INIT_N)
    else $error("init released after load error");
  AST_DATA_ON_RISE: assert property ($changed(READBACK_DATA) |->
    since_r inside {[4'h1:4'h6]}) else $error("data moved off a rise");
  AST_RIP_ON_RISE: assert property (
    $changed(READBACK_IN_PROGRESS) |-> since_r inside {[4'h1:4'h6]})
    else $error("busy moved off a rise");
  AST_LEAD_DUMMIES: assert property (s_rb_start |-> s_dummies)
    else $error("stream does not open high");
  AST_RIP_NEEDS_TRIG: assert property (s_rb_start |->
    READBACK_TRIGGER && $past(READBACK_TRIGGER, 8))
    else $error("busy without held trigger");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_READY_IN_ACCESS: assert property (PREADY |->
    PSEL && PENABLE && $past(PSEL && PENABLE))
    else $error("ready outside access phase");
  AST_UNMAPPED: assert property (PREADY && PADDR[11:4] != 8'h00 |->
    PSLVERR && PRDATA == 32'h0) else $error("unmapped not refused");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
endmodule // crs_serializer_checker
bind crs_serializer crs_serializer_checker crs_serializer_checker_i (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CFG_CLK(CFG_CLK), .READBACK_USER_CLK(READBACK_USER_CLK),
  .READBACK_TRIGGER(READBACK_TRIGGER), .INIT_N(INIT_N),
  .READBACK_DATA(READBACK_DATA),
  .READBACK_IN_PROGRESS(READBACK_IN_PROGRESS));

// ==== tb/crs_rb_host.sv ====
// partner model: user logic clocking and triggering readback
`timescale 1ns/100ps
module crs_rb_host (
  input wire clk,
  input wire sel,
  input wire data,
  input wire rip,
  output logic cclk = 1'b0,
  output logic uclk = 1'b0,
  output logic trig = 1'b0
);
  logic q_data[$];
  logic q_rip[$];
  // one 200 ns clock per loop; parked low between runs
  // runs above the 1 MHz ceiling only to keep runs short
  // samples taken just before each rise, where the bit has settled
  task automatic run(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk);
      q_data.push_back(data);
      q_rip.push_back(rip);
      if (sel)
        uclk <= 1'b1;
      else
        cclk <= 1'b1;
      repeat (4) @(posedge clk);
      uclk <= 1'b0;
      cclk <= 1'b0;
    end
  endtask
  // trigger moves only with the clock low and is held over whole runs
  task automatic set_trig(input logic v);
    trig <= v;
  endtask
endmodule // crs_rb_host

// ==== tb/tb_config_readback_serializer.sv ====
// self-checking bench for the readback serializer
`timescale 1ns/100ps
`include "crs_regs.vh"
`define CHK(a, b, m) begin \
  cmp_count++; \
  if ((a) !== (b)) begin \
    n_mismatch++; \
    $display("wrong value at %0t: %s", $time, m); \
  end \
end
module tb_config_readback_serializer;
  logic clk = 1'b0, rst = 1'b1, psel, penable;
  logic pwrite, cfg_clk_r, cfg_din, sel = 1'b0;
  logic ram_we = 1'b0, pready, pslverr, init_n, rb_data, rip;
  logic cclk, uclk, trig, err;
  // config clock pin is shared by the loader and the readback host
  wire cfg_clk = cfg_clk_r | cclk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] nodes = 8'h0, lat;
  logic [2:0] ram_frame = 3'h0;
  logic [15:0] ram_data = 16'h0, crc, fdat;
  logic [4:0] ctl;
  logic [15:0] mem [8];
  logic exp [184];
  int n_mismatch = 0, cmp_count = 0, seed = 32'h7AFE;
  crs_serializer crs_serializer_i (.CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CFG_CLK(cfg_clk), .CFG_DIN(cfg_din), .INIT_N(init_n),
    .READBACK_USER_CLK(uclk), .READBACK_TRIGGER(trig),
    .READBACK_DATA(rb_data), .READBACK_IN_PROGRESS(rip),
    .USER_NODES(nodes), .RAM_WE(ram_we), .RAM_FRAME(ram_frame),
    .RAM_DATA(ram_data));
  crs_rb_host crs_rb_host_i (.clk(clk), .sel(sel), .data(rb_data),
    .rip(rip), .cclk(cclk), .uclk(uclk), .trig(trig));
  // ********
  // helpers
  // ********
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CRS_CRC_POLY : 16'h0);
  endfunction
  // expected stream: dummies, frames with running crc, signature
  task automatic build();
    logic b;
    crc = 16'h0;
    for (int i = 0; i < 5; i++) exp[i] = 1'b1;
    for (int k = 0; k < 8; k++) begin
      for (int j = 0; j < 21; j++) begin
        b = (j == 0) ? 1'b0 : (j > 16) ? 1'b1 : mem[k][16 - j];
        if (k == 0 && j < 3 && j > 0) b = ctl[j + 2];
        if (j == 5) b = ctl[0] ? ~lat[k] : 1'b1;
        if (k == 7 && j > 9) b = 1'b1;
        exp[5 + 21 * k + j] = b;
        crc = crc_step(crc, b);
      end
    end
    for (int i = 0; i < 11; i++) exp[173 + i] = crc[15 - i];
  endtask
  // one apb transfer; waits for ready, takes data at that edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    `CHK(n, 2, "apb wait states")
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // config bits msb first, each held across a clock rise
  task automatic cfg_send(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      cfg_din <= v[i];
      repeat (4) @(posedge clk);
      cfg_clk_r <= 1'b1;
      repeat (4) @(posedge clk);
      cfg_clk_r <= 1'b0;
    end
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d, compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ********
  // stimulus
  // ********
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    #1000000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h0;
    pwdata <= 32'($random(seed));
    cfg_din <= 1'b1;
    cfg_clk_r <= 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `CRS_OFF_CTRL, 32'h0);
    `CHK(rd, 32'h0, "control reset value")
    apb(1'b1, `CRS_OFF_STATUS, 32'hFF);
    apb(1'b0, `CRS_OFF_STATUS, 32'h0);
    `CHK(rd, 32'h2, "status after reset")
    apb(1'b0, 12'h010, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0}, "unmapped access")
    // a load whose first frame carries wrong check bits
    apb(1'b1, `CRS_OFF_CTRL, 32'h10);
    cfg_send(32'h1F2, 9);
    cfg_send(32'hC8, 24);
    cfg_send(32'hF, 4);
    fdat = 16'($random(seed));
    crc = 16'h0;
    for (int j = 15; j >= 0; j--) crc = crc_step(crc, fdat[j]);
    cfg_send({11'h0, 1'b0, fdat, ~crc[3:0]}, 21);
    cfg_send(32'h78, 8);
    repeat (10) @(posedge clk);
    `CHK(init_n, 1'b0, "init after bad frame")
    apb(1'b0, `CRS_OFF_STATUS, 32'h0);
    `CHK(rd[2:1], 2'b10, "load error status")
    apb(1'b0, `CRS_OFF_LENGTH, 32'h0);
    `CHK(rd, 32'hC8, "length count")
    for (int k = 0; k < 8; k++) begin
      mem[k] = 16'($random(seed));
      ram_we <= 1'b1;
      ram_frame <= 3'(k);
      ram_data <= mem[k];
      @(posedge clk);
    end
    ram_we <= 1'b0;
    // capture on pin clock, capture off on user clock, then an abort
    for (int m = 0; m < 3; m++) begin
      ctl = {2'($random(seed)), m == 1, m == 2, m != 1};
      apb(1'b1, `CRS_OFF_CTRL, {27'h0, ctl});
      apb(1'b0, `CRS_OFF_CTRL, 32'h0);
      `CHK(rd, {27'h0, ctl}, "control readback")
      sel <= ctl[2];
      lat = 8'($random(seed));
      nodes <= lat;
      crs_rb_host_i.set_trig(1'b0);
      crs_rb_host_i.run(2);
      crs_rb_host_i.q_data.delete();
      crs_rb_host_i.q_rip.delete();
      crs_rb_host_i.set_trig(1'b1);
      crs_rb_host_i.run(3);
      nodes <= ~lat;
      crs_rb_host_i.run(m == 2 ? 37 : 183);
      crs_rb_host_i.set_trig(1'b0);
      crs_rb_host_i.run(16);
      build();
      for (int i = 0; i < 184; i++)
        if (m < 2 || i < 39)
          `CHK(crs_rb_host_i.q_data[i + 2], exp[i],
               "bit")
      if (m < 2) begin
        for (int i = 0; i < 186; i++)
          `CHK(crs_rb_host_i.q_rip[i], i > 1 && i < 185, "busy")
        apb(1'b0, `CRS_OFF_SIG, 32'h0);
        `CHK(rd, {21'h0, crc[15:5]}, "signature")
      end else begin
        for (int i = 41; i < 53; i++) begin
          `CHK(crs_rb_host_i.q_data[i], 1'b1, "drain")
          `CHK(crs_rb_host_i.q_rip[i], i < 52, "drain busy")
        end
      end
    end
    tally_and_finish();
  end
endmodule // tb_config_readback_serializer
